//--- vsc_pkg.sv
package vsc_pkg;

	// frame geometry
	localparam int          VSC_CTL_BITS   = 8;
	localparam int          VSC_DATA_BITS  = 16;
	localparam int          VSC_FRAME_BITS = VSC_CTL_BITS + VSC_DATA_BITS;
	localparam int          VSC_CNT_W      = 5;
	localparam logic [4:0]  VSC_CNT_LAST   = 5'h17;
	localparam logic [4:0]  VSC_CNT_DONE   = 5'h18;

	// field codes
	localparam logic [2:0]  VSC_AOUT_FEED_THROUGH = 3'h0;
	localparam logic [1:0]  VSC_AIN_GAIN_9DB      = 2'h1;
	localparam logic [1:0]  VSC_OUT_MUX_ANA_IN    = 2'h1;
	localparam logic [1:0]  VSC_AMP_SPKR_HI       = 2'h1;
	localparam logic [1:0]  VSC_MIX_OFF           = 2'h3;

	// reset contents: every stage powered down except the aux output
	localparam logic [15:0] VSC_ANALOG_PATH_CONFIG_ZERO_RST = 16'h2421;
	localparam logic [15:0] VSC_ANALOG_PATH_CONFIG_ONE_RST = 16'h01e3;
	localparam logic [15:0] VSC_ROW_RST  = 16'h0000;
	localparam logic [5:0]  VSC_STAT_PAD = 6'h00;

	typedef struct packed {
		logic run;
		logic play;
		logic power_on_control;
		logic skip_address_load;
		logic message_skip_enable;
		logic load_config_one;
		logic load_config_zero;
		logic unused;
	} vsc_ctl_t;

	typedef struct packed {
		vsc_ctl_t    ctl;
		logic [15:0] data;
	} vsc_frame_t;

	typedef struct packed {
		logic [5:0]  pad;
		logic        end_of_message_flag;
		logic        array_overflow_flag;
		logic [15:0] row_ptr;
	} vsc_status_t;

	typedef struct packed {
		logic [1:0] ana_in_gain;
		logic       ana_in_power_down;
		logic [1:0] aux_in_gain;
		logic       aux_in_power_down;
		logic       input_source_select;
		logic [2:0] analog_out_mux_select;
		logic       ana_out_power_down;
		logic [1:0] output_mux_select;
		logic [1:0] speaker_aux_amp_control;
		logic       attenuator_power_down;
	} vsc_analog_path_config_zero_t;

	typedef struct packed {
		logic [1:0] attenuator_source_select;
		logic [2:0] attenuation_level;
		logic [1:0] sum1_mux_select;
		logic [1:0] sum1_mixer_control;
		logic [1:0] sum2_mixer_control;
		logic       filter_source_select;
		logic [1:0] sample_rate_select;
		logic       filter_power_down;
		logic       agc_amp_power_down;
	} vsc_analog_path_config_one_t;

	// stage enables, 1 = powered
	typedef struct packed {
		logic ana_in;
		logic aux_in;
		logic ana_out;
		logic attenuator;
		logic filter;
		logic agc;
		logic speaker_hi;
		logic aux_out;
		logic mixers;
	} vsc_power_t;

endpackage : vsc_pkg

//--- vsc_sync2.sv
`timescale 1ns/1ns
`default_nettype none
module vsc_sync2 #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         clock,
	input  wire logic         reset_n,
	// levels
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_r;

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			meta_r <= '1;
			q      <= '1;
		end else begin
			meta_r <= d;
			q      <= meta_r;
		end
	end
endmodule : vsc_sync2
`default_nettype wire

//--- vsc_link.sv
`timescale 1ns/1ns
`default_nettype none
module vsc_link
	import vsc_pkg::*;
(
	// reset of the toggle only
	input  wire logic        reset_n,
	// serial pins
	input  wire logic        sclk,
	input  wire logic        ss_n,
	input  wire logic        mosi,
	output logic             miso,
	// to and from the system domain
	input  wire vsc_status_t status,
	output vsc_frame_t       frame,
	output logic             frame_tgl
);
	logic [VSC_CNT_W-1:0]      cnt_r;
	logic [VSC_FRAME_BITS-2:0] shift_r;
	logic [VSC_CNT_W-1:0]      idx;

	// slave select high holds the bit counter idle
	always_ff @(posedge sclk or posedge ss_n) begin
		if (ss_n) begin
			cnt_r <= '0;
		end else if (cnt_r != VSC_CNT_DONE) begin
			cnt_r <= cnt_r + 5'h01;
		end
	end

	always_ff @(posedge sclk) begin
		shift_r <= {shift_r[VSC_FRAME_BITS-3:0], mosi};
	end

	// whole frame latched on the 24th rising edge; extra bits ignored
	always_ff @(posedge sclk) begin
		if (cnt_r == VSC_CNT_LAST) begin
			frame <= {shift_r, mosi};
		end
	end

	always_ff @(posedge sclk or negedge reset_n) begin
		if (!reset_n) begin
			frame_tgl <= 1'b0;
		end else if (cnt_r == VSC_CNT_LAST) begin
			frame_tgl <= ~frame_tgl;
		end
	end

	// first bit is a pad zero, so ss_n can preload it
	assign idx = VSC_CNT_LAST - cnt_r;
	always_ff @(negedge sclk or posedge ss_n) begin
		if (ss_n) begin
			miso <= 1'b0;
		end else if (cnt_r < VSC_CNT_DONE) begin
			miso <= status[idx];
		end else begin
			miso <= 1'b0;
		end
	end
endmodule : vsc_link
`default_nettype wire

//--- vsc_ctrl.sv
// What this block does
// - control byte, then two address/config bytes
// - shift out row pointer plus status bits
// - run bit one starts if the power bit is one, zero stops
// - play/record bit: one play, zero record
// - power bit: one up, zero down
// - skip-address bit keeps internal pointer
// - cue bit enables or disables message cueing
// - load bits copy data into config registers
// - power-down bits: zero up, one down
// - analog-out mux zero selects feed-through
// - analog-in gain code one is 9 dB
// - output mux code one routes analog input
// - amp code one: speaker high, aux off
// - both mixer codes three power mixers down
// - both configs applied at select rise
// - config zero pending until one loaded
// - sample rising, drive falling, select framing
// - status flags cleared after next full 24-bit transaction
// - operation begins at select rising edge
`timescale 1ns/1ns
`default_nettype none
module vsc_ctrl
	import vsc_pkg::*;
(
	// system clock and reset
	input  wire logic        clock,
	input  wire logic        reset_n,
	// serial link
	input  wire logic        sclk,
	input  wire logic        ss_n,
	input  wire logic        mosi,
	output logic             miso,
	output logic             miso_oe,
	// storage array events
	input  wire logic        row_advance,
	input  wire logic        eom_event,
	input  wire logic        ovf_event,
	// operation state
	output logic             run_r,
	output logic             play_r,
	output logic             power_on_r,
	output logic             message_skip_enable_r,
	output logic [15:0]      row_ptr_r,
	output logic             end_of_message_flag_r,
	output logic             array_overflow_flag_r,
	// analog path settings
	output vsc_analog_path_config_zero_t        config_reg_zero_r,
	output vsc_analog_path_config_one_t        config_reg_one_r,
	output vsc_power_t       stage_power_r,
	output logic             feed_through_path_r,
	output logic             ana_in_gain_9db_r,
	output logic             out_mux_ana_in_r
);
	vsc_frame_t  frame;
	vsc_ctl_t    ctl;
	vsc_status_t status_r;
	logic        frame_tgl;
	logic [1:0]  sync_q;
	logic        ss_s;
	logic        tgl_s;
	logic        ss_d_r;
	logic        tgl_seen_r;
	logic        frame_go;
	logic [15:0] pend0_r;
	vsc_analog_path_config_zero_t   analog_path_config_zero_nxt;
	vsc_analog_path_config_one_t   analog_path_config_one_nxt;

	vsc_link u_link (
		.reset_n   (reset_n),
		.sclk      (sclk),
		.ss_n      (ss_n),
		.mosi      (mosi),
		.miso      (miso),
		.status    (status_r),
		.frame     (frame),
		.frame_tgl (frame_tgl)
	);

	vsc_sync2 #(.W(2)) u_sync (
		.clock   (clock),
		.reset_n (reset_n),
		.d       ({ss_n, ~frame_tgl}),
		.q       (sync_q)
	);

	assign ss_s  = sync_q[1];
	// toggle crosses inverted so the synchroniser reset level reads as idle
	assign tgl_s = ~sync_q[0];
	assign ctl   = frame.ctl;

	function automatic vsc_power_t power_decode(vsc_analog_path_config_zero_t c0, vsc_analog_path_config_one_t c1);
		vsc_power_t p;
		p.ana_in     = ~c0.ana_in_power_down;
		p.aux_in     = ~c0.aux_in_power_down;
		p.ana_out    = ~c0.ana_out_power_down;
		p.attenuator = ~c0.attenuator_power_down;
		p.filter     = ~c1.filter_power_down;
		p.agc        = ~c1.agc_amp_power_down;
		p.speaker_hi = (c0.speaker_aux_amp_control == VSC_AMP_SPKR_HI);
		p.aux_out    = (c0.speaker_aux_amp_control != VSC_AMP_SPKR_HI);
		p.mixers     = ~((c1.sum1_mixer_control == VSC_MIX_OFF) &&
			(c1.sum2_mixer_control == VSC_MIX_OFF));
		return p;
	endfunction : power_decode

	// frame taken only at select rise after a full 24-bit frame
	assign frame_go = ss_s & ~ss_d_r & (tgl_s != tgl_seen_r);

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			ss_d_r     <= 1'b1;
			tgl_seen_r <= 1'b0;
		end else begin
			ss_d_r <= ss_s;
			if (frame_go) begin
				tgl_seen_r <= tgl_s;
			end
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			miso_oe <= 1'b0;
		end else begin
			miso_oe <= ~ss_s;
		end
	end

	// operation control
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			run_r                 <= 1'b0;
			play_r                <= 1'b0;
			power_on_r            <= 1'b0;
			message_skip_enable_r <= 1'b0;
		end else if (frame_go) begin
			power_on_r            <= ctl.power_on_control;
			run_r                 <= ctl.run & ctl.power_on_control;
			play_r                <= ctl.play;
			message_skip_enable_r <= ctl.message_skip_enable;
		end else if (eom_event | ovf_event) begin
			run_r <= 1'b0;
		end
	end

	// row pointer
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			row_ptr_r <= VSC_ROW_RST;
		end else if (frame_go && ctl.run && !ctl.skip_address_load) begin
			row_ptr_r <= frame.data;
		end else if (run_r && row_advance) begin
			row_ptr_r <= row_ptr_r + 16'h0001;
		end
	end

	// sticky status; a new event beats the clear
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			end_of_message_flag_r <= 1'b0;
			array_overflow_flag_r <= 1'b0;
		end else begin
			end_of_message_flag_r <= eom_event | (end_of_message_flag_r & ~frame_go);
			array_overflow_flag_r <= ovf_event | (array_overflow_flag_r & ~frame_go);
		end
	end

	// status frozen while select is low so the link reads a still word
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			status_r <= '0;
		end else if (ss_s) begin
			status_r <= {VSC_STAT_PAD, end_of_message_flag_r,
				array_overflow_flag_r, row_ptr_r};
		end
	end

	// config zero waits in pending until config one is loaded
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			pend0_r <= VSC_ANALOG_PATH_CONFIG_ZERO_RST;
		end else if (frame_go && ctl.load_config_zero) begin
			pend0_r <= frame.data;
		end
	end

	always_comb begin
		analog_path_config_zero_nxt = config_reg_zero_r;
		analog_path_config_one_nxt = config_reg_one_r;
		if (frame_go && ctl.load_config_one) begin
			analog_path_config_zero_nxt = ctl.load_config_zero ? frame.data : pend0_r;
			analog_path_config_one_nxt = frame.data;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			config_reg_zero_r <= VSC_ANALOG_PATH_CONFIG_ZERO_RST;
			config_reg_one_r  <= VSC_ANALOG_PATH_CONFIG_ONE_RST;
		end else begin
			config_reg_zero_r <= analog_path_config_zero_nxt;
			config_reg_one_r  <= analog_path_config_one_nxt;
		end
	end

	// decoded analog controls follow the active registers
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			stage_power_r       <= power_decode(VSC_ANALOG_PATH_CONFIG_ZERO_RST, VSC_ANALOG_PATH_CONFIG_ONE_RST);
			feed_through_path_r <= 1'b1;
			ana_in_gain_9db_r   <= 1'b0;
			out_mux_ana_in_r    <= 1'b0;
		end else begin
			stage_power_r       <= power_decode(analog_path_config_zero_nxt, analog_path_config_one_nxt);
			feed_through_path_r <= (analog_path_config_zero_nxt.analog_out_mux_select == VSC_AOUT_FEED_THROUGH);
			ana_in_gain_9db_r   <= (analog_path_config_zero_nxt.ana_in_gain == VSC_AIN_GAIN_9DB);
			out_mux_ana_in_r    <= (analog_path_config_zero_nxt.output_mux_select == VSC_OUT_MUX_ANA_IN);
		end
	end

	// checks
	property p_run_bit;
		@(posedge clock) disable iff (!reset_n)
		frame_go |=> run_r == $past(ctl.run & ctl.power_on_control);
	endproperty
	a_run_bit: assert property (p_run_bit) else $error("run state wrong");

	property p_play_bit;
		@(posedge clock) disable iff (!reset_n)
		frame_go |=> play_r == $past(ctl.play);
	endproperty
	a_play_bit: assert property (p_play_bit) else $error("play state wrong");

	property p_power_bit;
		@(posedge clock) disable iff (!reset_n)
		frame_go |=> power_on_r == $past(ctl.power_on_control);
	endproperty
	a_power_bit: assert property (p_power_bit) else $error("power state wrong");

	property p_addr_load;
		@(posedge clock) disable iff (!reset_n)
		(frame_go && ctl.run && !ctl.skip_address_load) |=> row_ptr_r == $past(frame.data);
	endproperty
	a_addr_load: assert property (p_addr_load) else $error("address not loaded");

	property p_addr_skip;
		@(posedge clock) disable iff (!reset_n)
		(frame_go && ctl.skip_address_load && !row_advance) |=> $stable(row_ptr_r);
	endproperty
	a_addr_skip: assert property (p_addr_skip) else $error("address not ignored");

	property p_cue_bit;
		@(posedge clock) disable iff (!reset_n)
		frame_go |=> message_skip_enable_r == $past(ctl.message_skip_enable);
	endproperty
	a_cue_bit: assert property (p_cue_bit) else $error("cue state wrong");

	property p_no_load;
		@(posedge clock) disable iff (!reset_n)
		(frame_go && !ctl.load_config_zero && !ctl.load_config_one)
			|=> $stable(pend0_r) && $stable(config_reg_one_r);
	endproperty
	a_no_load: assert property (p_no_load) else $error("config changed without load");

	property p_analog_path_config_zero_pending;
		@(posedge clock) disable iff (!reset_n)
		!(frame_go && ctl.load_config_one) |=> $stable(config_reg_zero_r);
	endproperty
	a_analog_path_config_zero_pending: assert property (p_analog_path_config_zero_pending) else $error("config zero early");

	property p_flag_clear;
		@(posedge clock) disable iff (!reset_n)
		(frame_go && !eom_event) |=> !end_of_message_flag_r;
	endproperty
	a_flag_clear: assert property (p_flag_clear) else $error("status not cleared");

	property p_status_still;
		@(posedge clock) disable iff (!reset_n)
		(!ss_s && $past(!ss_s)) |-> $stable(status_r);
	endproperty
	a_status_still: assert property (p_status_still) else $error("status moved in frame");

	property p_feed_through;
		@(posedge clock) disable iff (!reset_n)
		(config_reg_zero_r.analog_out_mux_select == VSC_AOUT_FEED_THROUGH) |-> feed_through_path_r;
	endproperty
	a_feed_through: assert property (p_feed_through) else $error("feed-through not routed");

	property p_ovf_clear;
		@(posedge clock) disable iff (!reset_n)
		(frame_go && !ovf_event) |=> !array_overflow_flag_r;
	endproperty
	a_ovf_clear: assert property (p_ovf_clear) else $error("overflow not cleared");

	property p_event_stop;
		@(posedge clock) disable iff (!reset_n)
		(!frame_go && (eom_event || ovf_event)) |=> !run_r;
	endproperty
	a_event_stop: assert property (p_event_stop) else $error("event did not stop run");

	property p_row_step;
		@(posedge clock) disable iff (!reset_n)
		(!frame_go && run_r && row_advance) |=> row_ptr_r == $past(row_ptr_r) + 16'h0001;
	endproperty
	a_row_step: assert property (p_row_step) else $error("row pointer did not step");

	property p_analog_path_config_one_apply;
		@(posedge clock) disable iff (!reset_n)
		(frame_go && ctl.load_config_one) |=> config_reg_one_r == $past(frame.data);
	endproperty
	a_analog_path_config_one_apply: assert property (p_analog_path_config_one_apply) else $error("config one not applied");

	property p_analog_path_config_zero_take;
		@(posedge clock) disable iff (!reset_n)
		(frame_go && ctl.load_config_one && !ctl.load_config_zero)
			|=> config_reg_zero_r == $past(pend0_r);
	endproperty
	a_analog_path_config_zero_take: assert property (p_analog_path_config_zero_take) else $error("pending config zero lost");

	property p_stage_power;
		@(posedge clock) disable iff (!reset_n)
		(stage_power_r.ana_in == ~config_reg_zero_r.ana_in_power_down) &&
			(stage_power_r.filter == ~config_reg_one_r.filter_power_down);
	endproperty
	a_stage_power: assert property (p_stage_power) else $error("stage power wrong");

	property p_speaker_hi;
		@(posedge clock) disable iff (!reset_n)
		(config_reg_zero_r.speaker_aux_amp_control == VSC_AMP_SPKR_HI)
			|-> stage_power_r.speaker_hi && !stage_power_r.aux_out;
	endproperty
	a_speaker_hi: assert property (p_speaker_hi) else $error("speaker setting wrong");

	property p_mixers_off;
		@(posedge clock) disable iff (!reset_n)
		(config_reg_one_r.sum1_mixer_control == VSC_MIX_OFF &&
			config_reg_one_r.sum2_mixer_control == VSC_MIX_OFF) |-> !stage_power_r.mixers;
	endproperty
	a_mixers_off: assert property (p_mixers_off) else $error("mixers not powered down");

	property p_oe_idle;
		@(posedge clock) disable iff (!reset_n)
		ss_s |=> !miso_oe;
	endproperty
	a_oe_idle: assert property (p_oe_idle) else $error("miso driven while deselected");

	c_run_start: cover property (@(posedge clock) disable iff (!reset_n)
		frame_go && ctl.run ##1 run_r);
	c_cfg_both: cover property (@(posedge clock) disable iff (!reset_n)
		frame_go && ctl.load_config_one && !ctl.load_config_zero);
	c_eom_stop: cover property (@(posedge clock) disable iff (!reset_n)
		run_r && eom_event ##1 !run_r);
	c_flag_set: cover property (@(posedge clock) disable iff (!reset_n)
		eom_event ##1 end_of_message_flag_r);
endmodule : vsc_ctrl
`default_nettype wire

//--- vsc_host.sv
`timescale 1ns/1ns
`default_nettype none
module vsc_host (
	// serial pins, host side
	output logic      sclk,
	output logic      ss_n,
	output logic      mosi,
	input  wire logic miso
);
	initial begin
		sclk = 1'b0;
		ss_n = 1'b1;
		mosi = 1'b0;
	end

	// one frame of nbits, sclk idles low outside frames
	task automatic xfer(input logic [23:0] tx, input int nbits, output logic [23:0] rx);
		rx = 24'h0;
		#37 ss_n = 1'b0;
		mosi = tx[23];
		#400;
		for (int k = 0; k < nbits; k++) begin
			rx = {rx[22:0], miso};
			sclk = 1'b1;
			#80 sclk = 1'b0;
			mosi = (k < 23) ? tx[22-k] : ~mosi;
			#80;
		end
		#400 ss_n = 1'b1;
		mosi = ~mosi;
		#400;
	endtask : xfer
endmodule : vsc_host
`default_nettype wire

//--- vsc_ctrl_test.sv
`timescale 1ns/1ns
`default_nettype none
`define chk(nm, e, g) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
	$display("FAIL %s exp %h got %h", nm, e, g); end end
module vsc_ctrl_test
	import vsc_pkg::*;
;
	typedef struct packed {
		logic [7:0]  ctl;
		logic [15:0] data;
		logic [3:0]  exp;
		logic [15:0] row;
	} vsc_row_t;

	logic        clock;
	logic        reset_n;
	logic        sclk;
	logic        ss_n;
	logic        mosi;
	logic        miso;
	logic        miso_oe;
	logic [2:0]  ev;
	logic        run_r;
	logic        play_r;
	logic        power_on_r;
	logic        cue_r;
	logic [15:0] row_ptr_r;
	logic        eom_r;
	logic        ovf_r;
	vsc_analog_path_config_zero_t   analog_path_config_zero;
	vsc_analog_path_config_one_t   analog_path_config_one;
	vsc_power_t  pwr;
	logic        ft_r;
	logic        g9_r;
	logic        om_r;
	logic [23:0] rx;
	int          mismatches = 0;
	int          n_compared = 0;
	// exp = run, play, power, cue
	vsc_row_t    rows [8] = '{
		'{8'h20, 16'h0000, 4'h2, 16'h0000},
		'{8'he0, 16'h1234, 4'he, 16'h1234},
		'{8'hf0, 16'h5555, 4'he, 16'h1234},
		'{8'ha0, 16'h0040, 4'ha, 16'h0040},
		'{8'hf8, 16'hffff, 4'hf, 16'h0040},
		'{8'h30, 16'h0000, 4'h2, 16'h0040},
		'{8'h80, 16'h0040, 4'h0, 16'h0040},
		'{8'h10, 16'h9999, 4'h0, 16'h0040}};

	vsc_ctrl dut (
		.clock(clock), .reset_n(reset_n), .sclk(sclk), .ss_n(ss_n), .mosi(mosi),
		.miso(miso), .miso_oe(miso_oe), .row_advance(ev[2]), .eom_event(ev[1]),
		.ovf_event(ev[0]), .run_r(run_r), .play_r(play_r), .power_on_r(power_on_r),
		.message_skip_enable_r(cue_r), .row_ptr_r(row_ptr_r),
		.end_of_message_flag_r(eom_r), .array_overflow_flag_r(ovf_r),
		.config_reg_zero_r(analog_path_config_zero), .config_reg_one_r(analog_path_config_one), .stage_power_r(pwr),
		.feed_through_path_r(ft_r), .ana_in_gain_9db_r(g9_r), .out_mux_ana_in_r(om_r)
	);

	vsc_host host (
		.sclk(sclk), .ss_n(ss_n), .mosi(mosi), .miso(miso)
	);

	initial clock = 1'b0;
	always #50 clock = ~clock;

	task automatic close_out();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : close_out

	// frame, then let the system side act on it
	task automatic send(input logic [23:0] tx, input int n);
		host.xfer(tx, n, rx);
		repeat (2) @(posedge clock);
		#5;
	endtask : send

	task automatic ev_pulse(input logic [2:0] v);
		@(posedge clock);
		#5 ev = v;
		@(posedge clock);
		#5 ev = 3'h0;
		@(posedge clock);
		#5;
	endtask : ev_pulse

	initial begin
		#500_000;
		mismatches++;
		close_out();
	end

	initial begin
		reset_n = 1'b0;
		ev = 3'h0;
		repeat (3) @(posedge clock);
		#5 reset_n = 1'b1;
		repeat (3) @(posedge clock);
		#5;
		`chk("analog_path_config_zero reset", VSC_ANALOG_PATH_CONFIG_ZERO_RST, analog_path_config_zero)
		`chk("analog_path_config_one reset", VSC_ANALOG_PATH_CONFIG_ONE_RST, analog_path_config_one)
		`chk("oe reset", 1'b0, miso_oe)
		foreach (rows[i]) begin
			send({rows[i].ctl, rows[i].data}, 24);
			`chk("ctl bits", rows[i].exp, {run_r, play_r, power_on_r, cue_r})
			`chk("row pointer", rows[i].row, row_ptr_r)
		end
		send({8'h02, 16'h440b}, 24);
		`chk("analog_path_config_zero pending", VSC_ANALOG_PATH_CONFIG_ZERO_RST, analog_path_config_zero)
		send({8'h04, 16'h01e3}, 24);
		`chk("analog_path_config_zero applied", 16'h440b, analog_path_config_zero)
		`chk("analog_path_config_one applied", 16'h01e3, analog_path_config_one)
		`chk("decodes on", 3'h7, {ft_r, g9_r, om_r})
		`chk("stage power", 9'h144, pwr)
		send({8'h06, 16'ha1f4}, 24);
		`chk("both in one frame", 16'ha1f4, analog_path_config_one)
		`chk("decodes off", 3'h0, {ft_r, g9_r, om_r})
		`chk("stage power inverse", 9'h0b8, pwr & 9'h1f9)
		send({8'he0, 16'h0100}, 24);
		ev_pulse(3'h4);
		ev_pulse(3'h4);
		`chk("row advance", 16'h0102, row_ptr_r)
		ev_pulse(3'h2);
		`chk("eom stops", 2'h1, {run_r, eom_r})
		ev_pulse(3'h1);
		send({8'he0, 16'h0000}, 23);
		`chk("short frame ignored", 3'h3, {run_r, eom_r, ovf_r})
		fork
			send({8'h30, 16'h0000}, 24);
			#1000 `chk("oe in frame", 1'b1, miso_oe)
		join
		`chk("oe after frame", 1'b0, miso_oe)
		`chk("status word", {6'h00, 2'h3, 16'h0102}, rx)
		`chk("flags cleared", 2'h0, {eom_r, ovf_r})
		reset_n = 1'b0;
		repeat (2) @(posedge clock);
		#5 reset_n = 1'b1;
		repeat (2) @(posedge clock);
		#5;
		`chk("analog_path_config_zero after reset", VSC_ANALOG_PATH_CONFIG_ZERO_RST, analog_path_config_zero)
		`chk("power after reset", 9'h002, pwr)
		`chk("state after reset", 23'h0, {run_r, play_r, power_on_r, cue_r, eom_r, ovf_r, miso_oe, row_ptr_r})
		@(posedge clock);
		#5;
		send({8'he0, 16'h0055}, 24);
		`chk("ctl after reset", 4'he, {run_r, play_r, power_on_r, cue_r})
		`chk("row after reset", 16'h0055, row_ptr_r)
		close_out();
	end
endmodule : vsc_ctrl_test
`default_nettype wire
